// ---- design/dcs_pkg.sv ----
// Package for the debugger control and status block.
// Assumes a single 40 MHz system clock and a synchronous active-high reset.
package dcs_pkg;
    // Register indices on the plain register port
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_ACK_PORT = 2'h2;
    // Control register field positions
    localparam int CTL_DEBUG_STATE_BIT = 7;
    localparam int CTL_BREAK_EN_BIT = 6;
    localparam int CTL_ACK_EN_BIT = 5;
    localparam int CTL_RESET_BIT = 0;
    // Status register field positions
    localparam int STAT_DEBUG_BIT = 7;
    localparam int STAT_HALT_BIT = 6;
    localparam int STAT_GATE_BIT = 5;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Break opcode and acknowledge character
    localparam logic [7:0] BREAK_OPCODE = 8'h00;
    localparam logic [7:0] ACK_BYTE = 8'hFF;
    // Width of the device reset pulse, in ns and in clock cycles
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_PULSE_NS = 100;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // States of the acknowledge sender
    typedef enum logic [1:0] {ACK_IDLE, ACK_WAIT, ACK_SENT} dcs_ack_state_t;
endpackage : dcs_pkg

// ---- design/dcs_evt_if.sv ----
// Interface carrying halt events between the core and the acknowledge sender.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface dcs_evt_if;
    logic break_halt;
    logic ack_enable;
    logic ack_busy;
    modport core (output break_halt, output ack_enable, input ack_busy);
    modport sender (input break_halt, input ack_enable, output ack_busy);
endinterface : dcs_evt_if
`default_nettype wire

// ---- design/dcs_ack_sender.sv ----
// Acknowledge sender: hands one FFH byte to the serial link on a breakpoint halt.
// Assumes the link takes the byte when ack_ready is high.
`timescale 1ns/1ps
`default_nettype none
module dcs_ack_sender (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Event side
    dcs_evt_if.sender evt,
    // Link side
    output logic ack_valid,
    output logic [7:0] ack_data,
    input wire logic ack_ready
);
    dcs_pkg::dcs_ack_state_t state_reg;
    dcs_pkg::dcs_ack_state_t state_next;
    logic [7:0] data_reg;
    logic [7:0] data_next;

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        data_next = data_reg;
        case (state_reg)
            dcs_pkg::ACK_IDLE: begin
                if (evt.break_halt && evt.ack_enable) begin
                    state_next = dcs_pkg::ACK_WAIT;
                    data_next = dcs_pkg::ACK_BYTE;
                end
            end
            dcs_pkg::ACK_WAIT: begin
                if (ack_ready) begin
                    state_next = dcs_pkg::ACK_SENT;
                end
            end
            dcs_pkg::ACK_SENT: begin
                state_next = dcs_pkg::ACK_IDLE;
                data_next = 8'h00;
            end
            default: begin
                state_next = dcs_pkg::ACK_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= dcs_pkg::ACK_IDLE;
            data_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            data_reg <= data_next;
        end
    end

    assign ack_valid = (state_reg == dcs_pkg::ACK_WAIT);
    assign ack_data = data_reg;
    assign evt.ack_busy = (state_reg != dcs_pkg::ACK_IDLE);
endmodule : dcs_ack_sender
`default_nettype wire

// ---- design/dcs_top.sv ----
// Debugger control and status registers with halt, breakpoint and reset control.
// Assumes a plain register port on the 40 MHz system clock and synchronous reset.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dcs_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // CPU side
    input wire logic opcode_decode,
    input wire logic [7:0] opcode_byte,
    input wire logic cpu_halted,
    output logic fetch_stall,
    output logic device_reset_req,
    // Option bits
    input wire logic read_protect_option,
    input wire logic read_protect_gate,
    // Acknowledge byte toward the serial link
    output logic ack_valid,
    output logic [7:0] ack_data,
    input wire logic ack_ready
);
    dcs_evt_if evt ();

    logic debug_reg;
    logic debug_next;
    logic break_en_reg;
    logic break_en_next;
    logic ack_en_reg;
    logic ack_en_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [2:0] rst_cnt_reg;
    logic [2:0] rst_cnt_next;
    logic rst_out_reg;
    logic rst_out_next;
    logic ctl_wr;
    logic break_hit;
    logic protect_active;
    logic [7:0] control_view;
    logic [7:0] status_view;

    // Address decode used for both writes and reads
    function automatic logic hit(input logic [1:0] a, input logic [1:0] idx);
        hit = (a == idx);
    endfunction : hit

    assign ctl_wr = reg_wr && hit(reg_addr, dcs_pkg::ADDR_CONTROL);
    assign protect_active = read_protect_option && !read_protect_gate;
    // Breakpoint only when enabled; otherwise opcode passes as a no-op
    assign break_hit = opcode_decode && (opcode_byte == dcs_pkg::BREAK_OPCODE)
                       && break_en_reg;

    // Control register fields and debug state
    always_comb begin
        debug_next = debug_reg;
        break_en_next = break_en_reg;
        ack_en_next = ack_en_reg;
        if (ctl_wr) begin
            break_en_next = reg_wdata[dcs_pkg::CTL_BREAK_EN_BIT];
            ack_en_next = reg_wdata[dcs_pkg::CTL_ACK_EN_BIT];
            if (reg_wdata[dcs_pkg::CTL_DEBUG_STATE_BIT]) begin
                debug_next = 1'b1;
            end else if (!protect_active) begin
                debug_next = 1'b0;
            end
        end
        // Breakpoint set wins over a clearing write
        if (break_hit) begin
            debug_next = 1'b1;
        end
    end

    // Self-clearing reset trigger, stretched to a fixed pulse
    always_comb begin
        rst_cnt_next = rst_cnt_reg;
        rst_out_next = 1'b0;
        if (ctl_wr && reg_wdata[dcs_pkg::CTL_RESET_BIT]) begin
            rst_cnt_next = 3'(dcs_pkg::RESET_PULSE_CYCLES);
        end else if (rst_cnt_reg != 3'h0) begin
            rst_cnt_next = rst_cnt_reg - 3'h1;
        end
        rst_out_next = (rst_cnt_next != 3'h0);
    end

    // Register views with reserved bits at zero
    always_comb begin
        control_view = 8'h00;
        control_view[dcs_pkg::CTL_DEBUG_STATE_BIT] = debug_reg;
        control_view[dcs_pkg::CTL_BREAK_EN_BIT] = break_en_reg;
        control_view[dcs_pkg::CTL_ACK_EN_BIT] = ack_en_reg;
        status_view = 8'h00;
        status_view[dcs_pkg::STAT_DEBUG_BIT] = debug_reg;
        status_view[dcs_pkg::STAT_HALT_BIT] = cpu_halted;
        status_view[dcs_pkg::STAT_GATE_BIT] = read_protect_gate;
    end

    // Read data, valid only the cycle after the strobe
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            if (hit(reg_addr, dcs_pkg::ADDR_CONTROL)) begin
                rdata_next = control_view;
            end else if (hit(reg_addr, dcs_pkg::ADDR_STATUS)) begin
                rdata_next = status_view;
            end else begin
                rdata_next = 8'h00; // Unmapped reads zero
            end
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            debug_reg <= dcs_pkg::CONTROL_RESET[dcs_pkg::CTL_DEBUG_STATE_BIT];
            break_en_reg <= dcs_pkg::CONTROL_RESET[dcs_pkg::CTL_BREAK_EN_BIT];
            ack_en_reg <= dcs_pkg::CONTROL_RESET[dcs_pkg::CTL_ACK_EN_BIT];
            rdata_reg <= dcs_pkg::STATUS_RESET;
            rst_cnt_reg <= 3'h0;
            rst_out_reg <= 1'b0;
        end else begin
            debug_reg <= debug_next;
            break_en_reg <= break_en_next;
            ack_en_reg <= ack_en_next;
            rdata_reg <= rdata_next;
            rst_cnt_reg <= rst_cnt_next;
            rst_out_reg <= rst_out_next;
        end
    end

    // Acknowledge sender hookup
    // Only a fresh halt with the sender idle offers a byte
    assign evt.break_halt = break_hit && !debug_reg && !evt.ack_busy;
    assign evt.ack_enable = ack_en_reg;

    dcs_ack_sender u_ack (
        .clk(clk),
        .sys_rst(sys_rst),
        .evt(evt),
        .ack_valid(ack_valid),
        .ack_data(ack_data),
        .ack_ready(ack_ready)
    );

    // Outputs
    assign reg_rdata = rdata_reg;
    assign fetch_stall = debug_reg;
    assign device_reset_req = rst_out_reg;
endmodule : dcs_top
`default_nettype wire

// ---- sim/dcs_sva.sv ----
// Port checker for the debugger control block.
// Bound to dcs_top from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module dcs_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Watched ports
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic opcode_decode,
    input wire logic [7:0] opcode_byte,
    input wire logic cpu_halted,
    input wire logic fetch_stall,
    input wire logic device_reset_req,
    input wire logic read_protect_option,
    input wire logic read_protect_gate,
    input wire logic ack_valid,
    input wire logic [7:0] ack_data
);
    logic [1:0] en_reg;
    logic [1:0] en_next;
    logic cw;
    logic bk;
    logic lk;
    // Control write, break and lock decode
    assign cw = reg_wr && reg_addr == 2'h0;
    assign bk = opcode_decode && opcode_byte == 8'h00;
    assign lk = read_protect_option && !read_protect_gate;
    // Shadow of break and ack enables
    always_comb en_next = cw ? reg_wdata[6:5] : en_reg;
    always_ff @(posedge clk) en_reg <= sys_rst ? 2'h0 : en_next;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_set_debug: assert property (cw && reg_wdata[7] |=> fetch_stall)
        else $error("no halt");
    a_stall_holds: assert property (fetch_stall && !cw |=> fetch_stall)
        else $error("halt lost");
    a_clear_run: assert property (cw && !reg_wdata[7] && !lk && !(bk && en_reg[1])
        |=> !fetch_stall) else $error("no resume");
    a_break_halts: assert property (bk && en_reg[1] |=> fetch_stall)
        else $error("break missed");
    a_lock_holds: assert property (fetch_stall && lk |=> fetch_stall)
        else $error("lock broken");
    a_ack_sent: assert property (bk && en_reg == 2'h3 && !fetch_stall && !ack_valid
        && !$past(ack_valid) |=> ack_valid && ack_data == 8'hFF) else $error("no ack");
    a_status_read: assert property (reg_rd && reg_addr == 2'h1 |=>
        reg_rdata == {$past(fetch_stall), $past(cpu_halted), $past(read_protect_gate), 5'h00})
        else $error("status bad");
    a_reset_pulse: assert property (cw && reg_wdata[0] |=> device_reset_req [*4])
        else $error("reset short");
endmodule : dcs_sva
`default_nettype wire

// ---- sim/dcs_host_model.sv ----
// Host end of the serial link: takes acknowledge bytes.
// Assumes the bench sets slow to stretch the handshake.
`timescale 1ns/1ps
`default_nettype none
module dcs_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link
    input wire logic ack_valid,
    input wire logic [7:0] ack_data,
    input wire logic slow,
    output logic ack_ready,
    output var int got
);
    logic [1:0] wait_reg;
    // Prompt or late ready, count of FFH bytes taken
    always_ff @(posedge clk) begin
        wait_reg <= ack_valid ? wait_reg + 2'h1 : 2'h0;
        ack_ready <= ack_valid && !ack_ready && (!slow || wait_reg == 2'h3) && !sys_rst;
        if (sys_rst) got <= 0;
        else if (ack_valid && ack_ready && ack_data == 8'hFF) got <= got + 1;
    end
endmodule : dcs_host_model
`default_nettype wire

// ---- sim/debugger_control_status_regs_tb_top.sv ----
// Self-checking bench for the debugger control block.
// Assumes dcs_top, dcs_sva and dcs_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module debugger_control_status_regs_tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic opcode_decode = 1'b0;
    logic [7:0] opcode_byte = 8'h00;
    logic cpu_halted = 1'b0;
    logic fetch_stall;
    logic device_reset_req;
    logic read_protect_option = 1'b0;
    logic read_protect_gate = 1'b0;
    logic ack_valid;
    logic [7:0] ack_data;
    logic ack_ready;
    logic slow = 1'b0;
    logic st = 1'b0;
    logic [7:0] d;
    int got;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    dcs_top dut_u (.*);
    dcs_host_model host_u (.*);
    function automatic logic [7:0] stat(input logic g, input logic h, input logic p);
        return {g, h, p, 5'h00};
    endfunction : stat
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd
    task automatic issue_opcode(input logic [7:0] b);
        @(posedge clk);
        opcode_decode <= 1'b1;
        opcode_byte <= b;
        @(posedge clk);
        opcode_decode <= 1'b0;
        #1;
    endtask : issue_opcode
    task automatic tally_and_finish;
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc > 4000) begin
            fails++;
            tally_and_finish();
        end
    end
    // Main sequence
    initial begin
        d = 8'($urandom(41025));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd(2'h0, 8'h00);
        rd(2'h1, stat(1'b0, 1'b0, 1'b0));
        wr(2'h0, 8'h81);
        chk({fetch_stall, device_reset_req, 6'h00}, 8'hC0);
        rd(2'h0, 8'h80);
        wr(2'h0, 8'h40);
        chk({fetch_stall, device_reset_req, 6'h00}, 8'h00);
        // Any other opcode must not halt
        issue_opcode(d | 8'h01);
        chk(8'(fetch_stall), 8'h00);
        issue_opcode(8'h00);
        chk({fetch_stall, ack_valid, 6'h00}, 8'h80);
        wr(2'h0, 8'h60);
        slow <= 1'b1;
        issue_opcode(8'h00);
        chk({fetch_stall, ack_valid, 6'h00}, 8'hC0);
        repeat (8) @(posedge clk);
        #1;
        chk({ack_valid, 7'(got)}, 8'h01);
        // Prompt host, then a second break while already halted
        slow <= 1'b0;
        wr(2'h0, 8'h60);
        issue_opcode(8'h00);
        issue_opcode(8'h00);
        repeat (4) @(posedge clk);
        #1;
        chk({ack_valid, 7'(got)}, 8'h02);
        wr(2'h0, 8'h00);
        issue_opcode(8'h00);
        chk(8'(fetch_stall), 8'h00);
        read_protect_option <= 1'b1;
        wr(2'h0, 8'hA0);
        wr(2'h0, 8'h00);
        chk(8'(fetch_stall), 8'h01);
        rd(2'h1, stat(1'b1, 1'b0, 1'b0));
        read_protect_gate <= 1'b1;
        wr(2'h0, 8'h00);
        chk(8'(fetch_stall), 8'h00);
        wr(2'h2, 8'hFF);
        rd(2'h2, 8'h00);
        rd(2'h3, 8'h00);
        // Locked halt: only a system reset (sys_rst) leaves it
        read_protect_gate <= 1'b0;
        wr(2'h0, 8'hE0);
        chk(8'(fetch_stall), 8'h01);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk({fetch_stall, ack_valid, 6'h00}, 8'h00);
        rd(2'h0, 8'h00);
        repeat (24) begin
            d = 8'($urandom);
            cpu_halted <= d[1];
            read_protect_gate <= d[2];
            wr(2'h0, d & 8'hE1);
            st = d[7] | (st & !d[2]);
            chk({fetch_stall, device_reset_req, 6'h00}, {st, d[0], 6'h00});
            rd(2'h0, {st, d[6:5], 5'h00});
            rd(2'h1, stat(st, d[1], d[2]));
        end
        tally_and_finish();
    end
endmodule : debugger_control_status_regs_tb_top
bind dcs_top dcs_sva chk_u (.*);
`default_nettype wire
